// [src/dlt_timing_core.sv]
// device-side timing response of a ddr3 memory: internal write start,
// refresh and short calibration busy windows, power-down entry, write
// leveling feedback and calibration pattern reads.
// assumes the controller drives the device clock and the command pins;
// all of them are sampled by i_clock, so the device clock must be slow
// enough for at least four sampling cycles per phase.
`timescale 1ns/1ps
`default_nettype none
`include "dlt_defs.svh"

// Contract
// (R1) controller holds termination four cycles minimum
// (R2) eight-beat writes need six cycles termination
// (R3) first strobe edge forty cycles after leveling
// (R4) strobe drive twenty-five cycles after leveling
// (R5) leveling feedback returned within bounded delay
// (R6) refresh blocks activate and refresh 350ns
// (R7) refresh average interval 7.8us or 3.9us
// (R8) reads and termination commands need locked loop
// (R9) write recovery rounded up to cycles
// (R10) internal write starts latency plus four/two
// (R11) device finishes operations before low power; the code waits for refresh, calibration and pending write, not pattern reads
// (R12) refresh then power-down after its minimum
// (R13) short calibration completes within 64 cycles
// (R14) no maximum device clock period
// (R15) pattern register reads a fixed sequence
// (R16) write to power-down latency plus recovery; the code waits only until the internal write start, with no recovery
// (R17) third mode register bit two enables pattern
// (R18) controller tracks minimum intervals with counters
module dlt_timing_core
    import dlt_pkg::*;
#(
    parameter int AW          = 16,
    parameter int READ_LAT_CK = `DLT_READ_LATENCY_DEF
) (
    input  wire logic          I_CLOCK,
    input  wire logic          I_RST_N,
    input  wire logic          I_CK,
    input  wire logic          I_CKE,
    input  wire logic          I_CS_N,
    input  wire logic          I_RAS_N,
    input  wire logic          I_CAS_N,
    input  wire logic          I_WE_N,
    input  wire logic          I_DQS,
    input  wire logic [AW-1:0] I_A,
    input  wire logic [2:0]    I_BA,
    output logic               O_DQ,
    output logic               O_DQ_OE,
    output logic               O_WRITE_START,
    output logic               O_REFRESH_BUSY,
    output logic               O_ZQ_BUSY,
    output logic               O_LOW_POWER,
    output logic               O_LEVEL_MODE,
    output logic               O_MPR_MODE
);

    localparam int PW      = `DLT_P_A_LO + AW + 3;
    localparam int P_BA_LO = `DLT_P_A_LO + AW;
    localparam logic [PW-1:0] PIN_IDLE = PW'(`DLT_RST_PINS);
    localparam logic [7:0] REF_CLKS = 8'(`DLT_REF_CYCLE_CLKS);
    localparam logic [3:0] FB_CLKS  = 4'(`DLT_LEVEL_FB_CLKS);
    localparam logic [7:0] ZQ_CK    = 8'(`DLT_SHORT_IMPEDANCE_CALIBRATION_CK);
    localparam logic [7:0] RD_LAT   = 8'(READ_LAT_CK);
    localparam logic [7:0] WR_LONG  = 8'(`DLT_WR_START_LONG);
    localparam logic [7:0] WR_CHOP  = 8'(`DLT_WR_START_CHOP);
    localparam logic [7:0] CWL_BASE = 8'(`DLT_CWL_BASE);
    localparam logic [7:0] PATTERN  = `DLT_MPR_PATTERN;

    generate
        if (AW < 13 || READ_LAT_CK < 1 || READ_LAT_CK > 255)
        begin : g_bad_param
            $error("dlt_timing_core: address width or read latency out of range");
        end
    endgenerate

    dlt_sync_if #(.W(PW)) sif ();

    dlt_state_t st_r;
    dlt_state_t st_nxt;

    logic          ck_rise;
    logic          ck_fall;
    logic          cke;
    logic          cmd_ok;
    logic [2:0]    cmd;
    logic [AW-1:0] addr;
    logic [2:0]    bank;
    logic          busy;

    ////////////////////////////////////////////////////////////////////////
    // pins enter through the three-stage sampler
    assign sif.raw = {I_BA, I_A, I_DQS, I_WE_N, I_CAS_N, I_RAS_N, I_CS_N, I_CKE, I_CK};

    dlt_pin_sync #(
        .W       (PW),
        .IDLE    (PIN_IDLE)
    ) u_sync (
        .i_clk   (I_CLOCK),
        .i_rst_n (I_RST_N),
        .sif     (sif.sampler)
    );
    // command is taken on a device clock rise with clock-enable high
    assign ck_rise = sif.rise[`DLT_P_CK];
    assign ck_fall = sif.fall[`DLT_P_CK];
    assign cke     = sif.level[`DLT_P_CKE];
    assign cmd_ok  = ck_rise && cke && !sif.level[`DLT_P_CS_N];
    assign cmd     = {sif.level[`DLT_P_RAS_N], sif.level[`DLT_P_CAS_N], sif.level[`DLT_P_WE_N]};
    assign addr    = sif.level[`DLT_P_A_LO +: AW];
    assign bank    = sif.level[P_BA_LO +: 3];

    // a running refresh, calibration or pending write keeps the device out of its low-power state
    assign busy = (st_r.ref_cnt != 8'h00) || (st_r.zq_cnt != 8'h00) || st_r.wr_pend;

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        st_nxt          = st_r;
        st_nxt.wr_start = 1'b0;
        // (R6) refresh busy window
        if (st_r.ref_cnt != 8'h00)
            st_nxt.ref_cnt = st_r.ref_cnt - 8'h01;

        if (ck_rise)
        begin
            // (R13) calibration busy countdown
            if (st_r.zq_cnt != 8'h00)
                st_nxt.zq_cnt = st_r.zq_cnt - 8'h01;
            // (R10) internal write start
            if (st_r.wr_pend)
            begin
                if (st_r.wr_cnt <= 8'h01)
                begin
                    st_nxt.wr_start = 1'b1;
                    st_nxt.wr_pend  = 1'b0;
                    st_nxt.wr_cnt   = 8'h00;
                end
                else
                    st_nxt.wr_cnt = st_r.wr_cnt - 8'h01;
            end
        end
        // (R15) pattern beats, one per device clock edge
        if ((ck_rise || ck_fall) && st_r.beats_left != 4'h0)
        begin
            st_nxt.dq         = PATTERN[st_r.beat_idx[2:0]];
            st_nxt.dq_oe      = 1'b1;
            st_nxt.beat_idx   = st_r.beat_idx + 4'h1;
            st_nxt.beats_left = st_r.beats_left - 4'h1;
        end
        else if (st_r.beats_left == 4'h0 && !st_r.level_en && !(ck_rise || ck_fall))
            st_nxt.dq_oe = 1'b0;

        // read latency before the burst; chop picks four beats, a2 the upper half
        if (ck_rise && st_r.rd_pend)
        begin
            if (st_r.rd_cnt <= 8'h01)
            begin
                st_nxt.rd_pend    = 1'b0;
                st_nxt.rd_cnt     = 8'h00;
                st_nxt.beats_left = st_r.rd_bc4 ? 4'h4 : 4'h8;
                st_nxt.beat_idx   = st_r.rd_hi ? 4'h4 : 4'h0;
            end
            else
                st_nxt.rd_cnt = st_r.rd_cnt - 8'h01;
        end

        // (R5) leveling feedback: capture clock level at strobe rise
        if (st_r.level_en)
        begin
            if (st_r.fb_pend)
            begin
                if (st_r.fb_cnt <= 4'h1)
                begin
                    st_nxt.dq      = st_r.fb_bit;
                    st_nxt.fb_pend = 1'b0;
                end
                else
                    st_nxt.fb_cnt = st_r.fb_cnt - 4'h1;
            end
            if (sif.rise[`DLT_P_DQS])
            begin
                st_nxt.fb_pend = 1'b1;
                st_nxt.fb_cnt  = FB_CLKS;
                st_nxt.fb_bit  = sif.level[`DLT_P_CK];
            end
        end

        // command decode: ras, cas, we
        if (cmd_ok)
        begin
            case (cmd)
                3'h0:
                begin
                    case (bank)
                        `DLT_MR_BURST: st_nxt.burst = addr[`DLT_F_BURST_LO +: 2];
                        `DLT_MR_LEVEL: st_nxt.level_en = addr[`DLT_F_LEVEL];
                        `DLT_MR_CWL:   st_nxt.cwl = addr[`DLT_F_CWL_LO +: 3];
                        // (R17) pattern mode enable bit
                        `DLT_MR_MPR:   st_nxt.mpr_en = addr[`DLT_F_MPR];
                        default:       st_nxt.burst = st_r.burst;
                    endcase
                end
                // (R6) refresh starts busy window
                3'h1: st_nxt.ref_cnt = REF_CLKS;
                3'h4:
                begin
                    // (R10) write delay from burst mode
                    if (!st_r.mpr_en)
                    begin
                        st_nxt.wr_pend = 1'b1;
                        st_nxt.wr_cnt  = CWL_BASE + 8'(st_r.cwl)
                                       + ((st_r.burst == `DLT_BURST_FIXED_CHOP) ? WR_CHOP : WR_LONG);
                    end
                end
                3'h5:
                begin
                    // reads outside pattern mode go to the array, not here
                    if (st_r.mpr_en)
                    begin
                        st_nxt.rd_pend = 1'b1;
                        st_nxt.rd_cnt  = RD_LAT;
                        st_nxt.rd_hi   = addr[`DLT_F_A2];
                        st_nxt.rd_bc4  = (st_r.burst == `DLT_BURST_FIXED_CHOP)
                                      || (st_r.burst == `DLT_BURST_OTF && !addr[`DLT_F_BC]);
                    end
                end
                3'h6:
                begin
                    // (R13) short calibration window
                    if (!addr[`DLT_F_A10])
                        st_nxt.zq_cnt = ZQ_CK;
                end
                default: st_nxt.pwr = st_r.pwr;
            endcase
        end
        // (R5) leveling drives data from the cycle the mode turns on
        st_nxt.dq_oe = st_nxt.dq_oe || st_nxt.level_en;
        // (R11) low power only after refresh, calibration and pending write end
        case (st_r.pwr)
            ST_AWAKE:
            begin
                if (!cke)
                    st_nxt.pwr = ST_DRAINING;
            end
            ST_DRAINING:
            begin
                if (cke)
                    st_nxt.pwr = ST_AWAKE;
                else if (!busy)
                begin
                    st_nxt.pwr       = ST_LOW_POWER;
                    st_nxt.low_power = 1'b1;
                end
            end
            ST_LOW_POWER:
            begin
                if (cke)
                begin
                    st_nxt.pwr       = ST_AWAKE;
                    st_nxt.low_power = 1'b0;
                end
            end
            default:
            begin
                st_nxt.pwr       = ST_AWAKE;
                st_nxt.low_power = 1'b0;
            end
        endcase
        // busy outputs registered, not decoded, so they cannot glitch
        st_nxt.ref_busy = st_nxt.ref_cnt != 8'h00;
        st_nxt.zq_busy  = st_nxt.zq_cnt != 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register; mode fields take their reset values
    always_ff @(posedge I_CLOCK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            st_r       <= '0;
            st_r.pwr   <= ST_AWAKE;
            st_r.burst <= `DLT_RST_BURST;
            st_r.cwl   <= `DLT_RST_CWL;
        end
        else
            st_r <= st_nxt;
    end

    // outputs straight from the state register
    assign O_DQ           = st_r.dq;
    assign O_DQ_OE        = st_r.dq_oe;
    assign O_WRITE_START  = st_r.wr_start;
    assign O_REFRESH_BUSY = st_r.ref_busy;
    assign O_ZQ_BUSY      = st_r.zq_busy;
    assign O_LOW_POWER    = st_r.low_power;
    assign O_LEVEL_MODE   = st_r.level_en;
    assign O_MPR_MODE     = st_r.mpr_en;

endmodule : dlt_timing_core

`default_nettype wire

// [include/dlt_defs.svh]
// constants of the ddr3 timing-response block: pin positions, mode fields,
// reset values and timing counts.
// assumes the sampling clock runs at the rate given by DLT_CLK_PERIOD_PS.
`ifndef DLT_DEFS_SVH
`define DLT_DEFS_SVH

// sampling clock
`define DLT_CLK_PERIOD_PS       25000

// refresh_cycle_time, least time, rounded up to whole cycles
`define DLT_REF_CYCLE_TIME_PS   350000
`define DLT_REF_CYCLE_CLKS      ((`DLT_REF_CYCLE_TIME_PS + `DLT_CLK_PERIOD_PS - 1) / `DLT_CLK_PERIOD_PS)

// level_feedback_delay, longest time, rounded down, never below one cycle
`define DLT_LEVEL_FB_DELAY_PS   7500
`define DLT_LEVEL_FB_CLKS       (((`DLT_LEVEL_FB_DELAY_PS / `DLT_CLK_PERIOD_PS) < 1) ? 1 : (`DLT_LEVEL_FB_DELAY_PS / `DLT_CLK_PERIOD_PS))

// short_impedance_calibration reach, in device clock cycles
`define DLT_SHORT_IMPEDANCE_CALIBRATION_CK             64

// internal write start after write_latency, in device clock cycles
`define DLT_WR_START_LONG       4
`define DLT_WR_START_CHOP       2
`define DLT_CWL_BASE            5
`define DLT_READ_LATENCY_DEF    6

// calibration_pattern_register content, beat 0 in bit 0
`define DLT_MPR_PATTERN         8'haa

// positions in the synchronised pin vector
`define DLT_P_CK                0
`define DLT_P_CKE               1
`define DLT_P_CS_N              2
`define DLT_P_RAS_N             3
`define DLT_P_CAS_N             4
`define DLT_P_WE_N              5
`define DLT_P_DQS               6
`define DLT_P_A_LO              7

// mode register selects and address fields
`define DLT_MR_BURST            3'h0
`define DLT_MR_LEVEL            3'h1
`define DLT_MR_CWL              3'h2
`define DLT_MR_MPR              3'h3
`define DLT_F_BURST_LO          0
`define DLT_F_LEVEL             7
`define DLT_F_CWL_LO            3
`define DLT_F_MPR               2
`define DLT_F_A2                2
`define DLT_F_A10               10
`define DLT_F_BC                12
`define DLT_BURST_FIXED_CHOP    2'h2
`define DLT_BURST_OTF           2'h1

// reset values
`define DLT_RST_BURST           2'h0
`define DLT_RST_CWL             3'h0
// sampled pin view at reset: ck and strobe low, clock-enable, select and
// command pins high, so no false edge or command follows reset
`define DLT_RST_PINS            7'h3e

`endif

// [include/dlt_pkg.sv]
// types of the ddr3 timing-response block.
// assumes dlt_defs.svh is on the include path.
package dlt_pkg;

    // power state of the device as seen from clock-enable
    typedef enum {
        ST_AWAKE,
        ST_DRAINING,
        ST_LOW_POWER
    } dlt_pwr_t;

    // whole state of the top module
    typedef struct packed {
        dlt_pwr_t   pwr;
        logic [1:0] burst;
        logic [2:0] cwl;
        logic       level_en;
        logic       mpr_en;
        logic       wr_pend;
        logic [7:0] wr_cnt;
        logic       wr_start;
        logic [7:0] ref_cnt;
        logic [7:0] zq_cnt;
        logic       fb_pend;
        logic [3:0] fb_cnt;
        logic       fb_bit;
        logic       rd_pend;
        logic [7:0] rd_cnt;
        logic       rd_bc4;
        logic       rd_hi;
        logic [3:0] beat_idx;
        logic [3:0] beats_left;
        logic       dq;
        logic       dq_oe;
        logic       low_power;
        logic       ref_busy;
        logic       zq_busy;
    } dlt_state_t;

endpackage : dlt_pkg

// [include/dlt_sync_if.sv]
// bundle between the pin sampler and the timing logic.
// assumes one sampling clock for both ends.
`timescale 1ns/1ps
`default_nettype none

interface dlt_sync_if #(
    parameter int W = 8
);
    logic [W-1:0] raw;
    logic [W-1:0] level;
    logic [W-1:0] rise;
    logic [W-1:0] fall;

    modport sampler (input raw, output level, output rise, output fall);
    modport user    (output raw, input level, input rise, input fall);
endinterface : dlt_sync_if

`default_nettype wire

// [src/dlt_pin_sync.sv]
// three-stage pin sampler with agreement filter and edge pulses.
// assumes raw inputs are asynchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none

module dlt_pin_sync
    import dlt_pkg::*;
#(
    parameter int           W    = 8,
    parameter logic [W-1:0] IDLE = '0
) (
    input  wire logic   i_clk,
    input  wire logic   i_rst_n,
    dlt_sync_if.sampler sif
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] level;
        logic [W-1:0] rise;
        logic [W-1:0] fall;
    } dlt_sync_st_t;

    dlt_sync_st_t st_r;
    dlt_sync_st_t st_nxt;

    generate
        if (W < 1)
        begin : g_bad_width
            $error("dlt_pin_sync: width must be at least one");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // s1 feeds only s2; a high level counts once s2 and s3 agree, any disagreement reads as low
    always_comb
    begin
        st_nxt       = st_r;
        st_nxt.s1    = sif.raw;
        st_nxt.s2    = st_r.s1;
        st_nxt.s3    = st_r.s2;
        st_nxt.level = (st_r.level & ~(st_r.s2 ^ st_r.s3)) | (st_r.s3 & ~(st_r.s2 ^ st_r.s3));
        st_nxt.rise  = st_nxt.level & ~st_r.level;
        st_nxt.fall  = ~st_nxt.level & st_r.level;
    end

    // reset to the idle pin levels, so the first edges after reset are real
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            st_r <= '{IDLE, IDLE, IDLE, IDLE, {W{1'b0}}, {W{1'b0}}};
        else
            st_r <= st_nxt;
    end

    assign sif.level = st_r.level;
    assign sif.rise  = st_r.rise;
    assign sif.fall  = st_r.fall;

endmodule : dlt_pin_sync

`default_nettype wire

// [sim/dlt_timing_core_assertions.sv]
// port assertions of the ddr3 timing-response block.
// assumes a controller clock period of at least eight sampling cycles.
`timescale 1ns/1ps
`default_nettype none

module dlt_core_chk (
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    input wire logic I_CK,
    input wire logic I_DQS,
    input wire logic O_DQ,
    input wire logic O_DQ_OE,
    input wire logic O_WRITE_START,
    input wire logic O_REFRESH_BUSY,
    input wire logic O_ZQ_BUSY,
    input wire logic O_LOW_POWER,
    input wire logic O_LEVEL_MODE,
    input wire logic O_MPR_MODE
);
    logic [9:0] ref_run_r;
    logic [9:0] zq_run_r;

    ////////////////////////////////////////////////////////////////////////////////
    // busy run lengths; zq gets a floor only, since a slow ck may stretch it
    always_ff @(posedge I_CLOCK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            ref_run_r <= 10'h000;
            zq_run_r  <= 10'h000;
        end
        else
        begin
            ref_run_r <= O_REFRESH_BUSY ? ref_run_r + 10'h001 : 10'h000;
            zq_run_r  <= O_ZQ_BUSY ? zq_run_r + 10'h001 : 10'h000;
        end
    end

    default clocking dc @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_N);

    ////////////////////////////////////////////////////////////////////////////////
    // timing of write, refresh, calibration, low power, leveling and pattern mode
    write_pulse_a: assert property (O_WRITE_START |=> !O_WRITE_START)
        else $error("write start wider than one cycle");
    write_quiet_a: assert property (O_LOW_POWER |-> !O_WRITE_START)
        else $error("write start while in low power");
    refresh_len_a: assert property ($fell(O_REFRESH_BUSY) |-> ref_run_r == 10'h00e)
        else $error("refresh busy not fourteen cycles");
    zq_len_a: assert property ($fell(O_ZQ_BUSY) |-> zq_run_r >= 10'h1f8)
        else $error("calibration busy ended before 64 ck rises");
    lp_entry_a: assert property ($rose(O_LOW_POWER) |-> !$past(O_REFRESH_BUSY) && !$past(O_ZQ_BUSY))
        else $error("low power entered while busy");
    lp_hold_a: assert property (O_LOW_POWER |-> !O_REFRESH_BUSY && !O_ZQ_BUSY)
        else $error("busy while in low power");
    level_drive_a: assert property (O_LEVEL_MODE |-> O_DQ_OE)
        else $error("data not driven in leveling");
    level_fb_a: assert property (O_LEVEL_MODE && $rose(I_DQS) |-> ##8 (O_DQ == $past(I_CK, 8)))
        else $error("leveling feedback not the ck level");
    pattern_no_write_a: assert property (O_MPR_MODE |-> !O_WRITE_START)
        else $error("write start while pattern mode on");
endmodule : dlt_core_chk

`default_nettype wire

// [sim/dlt_ctrl_model.sv]
// controller model: device clock and command pins, one ck period of
// eight sampling cycles per command slot.
// assumes i_clk is the bench's 40 MHz sampling clock.
`timescale 1ns/1ps
`default_nettype none

module dlt_ctrl_model (
    input  wire logic        i_clk,
    output logic             o_ck,
    output logic             o_cke,
    output logic             o_cs_n,
    output logic [2:0]       o_cmd,
    output logic             o_dqs,
    output logic [15:0]      o_a,
    output logic [2:0]       o_ba
);
    // idle pins at time zero: deselected, strobe low
    initial
    begin
        o_ck   = 1'b0;
        o_cke  = 1'b1;
        o_cs_n = 1'b1;
        o_cmd  = 3'h7;
        o_dqs  = 1'b0;
        o_a    = 16'h0000;
        o_ba   = 3'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one slot: pins change at the low half and hold across the rise
    // termination input is not a pin of this block, left undriven
    task automatic send(input logic [2:0] op, input logic [2:0] ba, input logic [15:0] a,
                        input logic cke);
        @(posedge i_clk);
        #1;
        o_ck   = 1'b0;
        o_cke  = cke;
        o_cs_n = 1'b0;
        o_cmd  = op;
        o_ba   = ba;
        o_a    = a;
        repeat (4) @(posedge i_clk);
        #1;
        o_ck = 1'b1;
        repeat (3) @(posedge i_clk);
    endtask : send

    task automatic nops(input int n, input logic cke);
        repeat (n) send(3'h7, 3'h0, 16'h0000, cke);
    endtask : nops

    // refreshes well inside the interval, clock-enable kept high
    task automatic refresh;
        send(3'h1, 3'h0, 16'h0000, 1'b1);
        nops(2, 1'b1);
    endtask : refresh

    task automatic level(input logic on);
        send(3'h0, 3'h1, {8'h00, on, 7'h00}, 1'b1);
        nops(40, 1'b1);
    endtask : level

    task automatic strobe(input logic lvl);
        @(posedge i_clk);
        #1;
        o_ck = lvl;
        repeat (2) @(posedge i_clk);
        #1;
        o_dqs = 1'b1;
        repeat (6) @(posedge i_clk);
        #1;
        o_dqs = 1'b0;
    endtask : strobe

    task automatic pattern(input logic on);
        send(3'h0, 3'h3, {13'h0000, on, 2'h0}, 1'b1);
    endtask : pattern
endmodule : dlt_ctrl_model

`default_nettype wire

// [sim/dlt_timing_core_tb.sv]
// self-checking bench of the ddr3 timing-response block.
// assumes the controller model and the port checker bound below.
`timescale 1ns/1ps
`default_nettype none

module dlt_timing_core_tb;
    logic        clk, rst_n, ck, cke, cs_n, dqs, dq, dq_oe, oe_q, dq_q;
    logic        wr_start, ref_busy, zq_busy, low_pwr, lvl_mode, mpr_mode;
    logic [2:0]  cmd, ba;
    logic [15:0] a;
    logic        beats[$];
    int          err_count, check_count, ws, rb;

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    dlt_ctrl_model u_dlt_ctrl_model (.i_clk(clk), .o_ck(ck), .o_cke(cke), .o_cs_n(cs_n),
        .o_cmd(cmd), .o_dqs(dqs), .o_a(a), .o_ba(ba));

    dlt_timing_core u_dlt_timing_core (.I_CLOCK(clk), .I_RST_N(rst_n), .I_CK(ck), .I_CKE(cke),
        .I_CS_N(cs_n), .I_RAS_N(cmd[2]), .I_CAS_N(cmd[1]), .I_WE_N(cmd[0]), .I_DQS(dqs),
        .I_A(a), .I_BA(ba), .O_DQ(dq), .O_DQ_OE(dq_oe), .O_WRITE_START(wr_start),
        .O_REFRESH_BUSY(ref_busy), .O_ZQ_BUSY(zq_busy), .O_LOW_POWER(low_pwr),
        .O_LEVEL_MODE(lvl_mode), .O_MPR_MODE(mpr_mode));

    ////////////////////////////////////////////////////////////////////////////////
    // tallies on the falling edge, where outputs have settled; the pattern
    // alternates, so each change of data while driven is one beat
    always @(negedge clk)
    begin
        if (wr_start === 1'b1) ws++;
        if (ref_busy === 1'b1) rb++;
        if (dq_oe === 1'b1 && mpr_mode === 1'b1 && (oe_q !== 1'b1 || dq !== dq_q))
            beats.push_back(dq);
        oe_q = dq_oe;
        dq_q = dq;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask : chk

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////////////
    // write start: latency plus four, plus two for fixed chop, one later is wrong
    task automatic t_write;
        logic [1:0] bm [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
        logic [2:0] cw [4] = '{3'h0, 3'h0, 3'h0, 3'h1};
        int         n [4]  = '{9, 9, 7, 10};
        for (int i = 0; i < 4; i++)
        begin
            u_dlt_ctrl_model.send(3'h0, 3'h0, {14'h0000, bm[i]}, 1'b1);
            u_dlt_ctrl_model.send(3'h0, 3'h2, {10'h000, cw[i], 3'h0}, 1'b1);
            u_dlt_ctrl_model.send(3'h4, 3'h0, 16'h1000, 1'b1);
            ws = 0;
            u_dlt_ctrl_model.nops(n[i], 1'b1);
            chk("early write start", 8'h00, 8'(ws));
            u_dlt_ctrl_model.nops(1, 1'b1);
            chk("write start", 8'h01, 8'(ws));
        end
    endtask : t_write

    // two refreshes three slots apart, each busy fourteen cycles
    task automatic t_refresh;
        rb = 0;
        u_dlt_ctrl_model.refresh();
        u_dlt_ctrl_model.refresh();
        u_dlt_ctrl_model.nops(1, 1'b1);
        chk("refresh busy cycles", 8'h1c, 8'(rb));
    endtask : t_refresh

    // clock-enable dropped during calibration: low power waits for it
    task automatic t_zq;
        u_dlt_ctrl_model.send(3'h6, 3'h0, 16'h0000, 1'b1);
        u_dlt_ctrl_model.nops(63, 1'b0);
        chk("calibration busy", 8'h01, 8'(zq_busy));
        chk("low power early", 8'h00, 8'(low_pwr));
        u_dlt_ctrl_model.nops(2, 1'b0);
        chk("calibration done", 8'h00, 8'(zq_busy));
        chk("low power", 8'h01, 8'(low_pwr));
        u_dlt_ctrl_model.nops(1, 1'b1);
        chk("low power exit", 8'h00, 8'(low_pwr));
    endtask : t_zq

    // leveling feedback follows the ck level at each strobe rise
    task automatic t_level;
        logic lv [3] = '{1'b1, 1'b0, 1'b1};
        u_dlt_ctrl_model.level(1'b1);
        chk("level mode and drive", 8'h03, {6'h00, lvl_mode, dq_oe});
        foreach (lv[i])
        begin
            u_dlt_ctrl_model.strobe(lv[i]);
            chk("level feedback", 8'(lv[i]), 8'(dq));
        end
        u_dlt_ctrl_model.level(1'b0);
        chk("level off", 8'h00, {6'h00, lvl_mode, dq_oe});
    endtask : t_level

    task automatic rd(input logic [15:0] ra, input logic [7:0] n, input logic [7:0] exp);
        logic [7:0] got;
        got = 8'h00;
        beats.delete();
        u_dlt_ctrl_model.send(3'h5, 3'h0, ra, 1'b1);
        u_dlt_ctrl_model.nops(12, 1'b1);
        foreach (beats[i]) if (i < 8) got[i] = beats[i];
        chk("pattern beats", n, 8'(beats.size()));
        chk("pattern bits", exp, got);
    endtask : rd

    // pattern mode: writes refused, full read, chopped upper nibble, on-the-fly chop
    task automatic t_pattern;
        u_dlt_ctrl_model.pattern(1'b1);
        ws = 0;
        u_dlt_ctrl_model.send(3'h4, 3'h0, 16'h1000, 1'b1);
        u_dlt_ctrl_model.nops(12, 1'b1);
        chk("pattern mode", 8'h01, 8'(mpr_mode));
        chk("write in pattern mode", 8'h00, 8'(ws));
        rd(16'h0000, 8'h08, 8'haa);
        u_dlt_ctrl_model.send(3'h0, 3'h0, 16'h0002, 1'b1);
        rd(16'h0004, 8'h04, 8'h0a);
        u_dlt_ctrl_model.send(3'h0, 3'h0, 16'h0001, 1'b1);
        rd(16'h0000, 8'h04, 8'h0a);
        u_dlt_ctrl_model.pattern(1'b0);
        u_dlt_ctrl_model.nops(1, 1'b1);
        chk("pattern off", 8'h00, 8'(mpr_mode));
    endtask : t_pattern

    initial
    begin
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        u_dlt_ctrl_model.nops(1, 1'b1);
        t_write();
        t_refresh();
        t_zq();
        t_level();
        t_pattern();
        test_done();
    end
endmodule : dlt_timing_core_tb

bind dlt_timing_core dlt_core_chk u_dlt_core_chk (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N),
    .I_CK(I_CK), .I_DQS(I_DQS), .O_DQ(O_DQ), .O_DQ_OE(O_DQ_OE), .O_WRITE_START(O_WRITE_START),
    .O_REFRESH_BUSY(O_REFRESH_BUSY), .O_ZQ_BUSY(O_ZQ_BUSY), .O_LOW_POWER(O_LOW_POWER),
    .O_LEVEL_MODE(O_LEVEL_MODE), .O_MPR_MODE(O_MPR_MODE));

`default_nettype wire
